// *** rtl/gpcfg_top.v ***
// Local design decision: register access over Avalon-MM.
`include "gpcfg_regs.vh"
// Summary of operation
// - Analog mux A control connects pin to analog path A; resets off.
// - Pull-up control attaches the pull-up resistor; resets off.
// - Pull-down control attaches the pull-down resistor; resets off.
// - Each input config register holds enables for interrupt lines A and B.
// - Rising edge sets rise flag if rise enable and a line enable are set; writing rise enable 0 clears it.
// - Falling edge sets fall flag if fall enable and a line enable are set; writing fall enable 0 clears it.
// - Input buffer enable gates pin input; disabled buffer outputs 0.
// - Each output change compares against input three cycles later; mismatch flags.
// - Drive-check mismatch interrupts only when a line enable is set.
// - Writing drive-check enable 0 disables check and clears its flag.
// - Filtered status shows debounced input feeding interrupts and port data.
// - Raw status shows input buffer output before the filter.
// - Filter select: off, 4, 16 or 64 slow oscillator periods.
// - Sixteen byte-wide input config registers at their base, reset 0x00.
// - Per-port function select registers, read/write, reset 0x00.
// - During and after reset both output drivers are off.
// - Edge logic captures rising and falling edges of filtered input.
// - Input invert bit reverses the input level.
// - Separate enables turn on high-side and low-side drivers; reset off.
module gpcfg_top (
   input wire i_sys_clk,
   input wire i_rst,
   input wire [17:0] i_avs_address,
   input wire i_avs_read,
   input wire i_avs_write,
   input wire [31:0] i_avs_writedata,
   input wire [3:0] i_avs_byteenable,
   output reg [31:0] o_avs_readdata,
   output reg o_avs_waitrequest,
   input wire [15:0] i_pin_in,
   output reg [15:0] o_pin_out,
   output reg [15:0] o_pin_oe,
   input wire [15:0] i_port_out_data,
   input wire i_slow_osc_clk,
   output wire [15:0] o_pullup_on,
   output wire [15:0] o_pulldown_on,
   output wire [15:0] o_analog_mux_a_on,
   output wire [15:0] o_analog_mux_b_on,
   output wire [15:0] o_input_buffer_on,
   output wire [15:0] o_filtered_level,
   output reg [127:0] o_function_select_value,
   output reg o_pin_irq_line_a,
   output reg o_pin_irq_line_b
);

   // ----------------------------------------------------------------
   // Configuration storage
   // ----------------------------------------------------------------
   reg [15:0] input_invert_reg;
   reg [15:0] high_side_drive_on_reg;
   reg [15:0] low_side_drive_on_reg;
   reg [15:0] out_invert_reg;
   reg [15:0] analog_mux_b_on_reg;
   reg [15:0] analog_mux_a_on_reg;
   reg [15:0] pullup_on_reg;
   reg [15:0] pulldown_on_reg;
   reg [15:0] pin_irq_line_b_on_reg;
   reg [15:0] pin_irq_line_a_on_reg;
   reg [15:0] rise_edge_irq_on_reg;
   reg [15:0] fall_edge_irq_on_reg;
   reg [15:0] input_buffer_on_reg;
   reg [15:0] drive_check_on_reg;
   reg [31:0] filter_time_sel_reg;

   // ----------------------------------------------------------------
   // Hardware state
   // ----------------------------------------------------------------
   reg [15:0] rise_edge_flag_reg;
   reg [15:0] fall_edge_flag_reg;
   reg [15:0] drive_check_flag_reg;
   reg [15:0] pin_s1_reg;
   reg [15:0] pin_s2_reg;
   reg osc_s1_reg;
   reg osc_s2_reg;
   reg osc_s3_reg;
   reg slow_osc_tick_reg;
   reg [15:0] filt_prev_reg;
   reg [15:0] drv_prev_reg;
   reg [15:0] chk_pipe_reg [0:`GPCFG_CHK_DELAY-1];
   reg [15:0] exp_pipe_reg [0:`GPCFG_CHK_DELAY-1];
   reg [7:0] rd_next;

   wire [15:0] filtered_level;
   wire [15:0] raw_level;
   wire [15:0] in_level;
   wire [15:0] rise_evt;
   wire [15:0] fall_evt;
   wire [15:0] line_any_on;
   wire [15:0] mismatch;
   wire [15:0] rise_clr;
   wire [15:0] fall_clr;
   wire [15:0] chk_clr;
   wire [15:0] drv_next;
   wire [15:0] oe_next;
   wire [15:0] flag_any;
   wire [15:0] pin_sel;
   wire [15:0] reg_idx;
   wire [3:0] sel_idx;
   wire [7:0] wd;
   wire req;
   wire wr_go;
   wire hit_ocfg;
   wire hit_icfg;
   wire hit_mfs;
   integer i;
   integer j;
   genvar g;

   // ----------------------------------------------------------------
   // Address decode
   // ----------------------------------------------------------------
   function in_blk;
      input [15:0] idx;
      input [15:0] base;
      begin
         in_blk = (idx[15:4] == base[15:4]);
      end
   endfunction

   assign reg_idx = i_avs_address[17:2];
   assign hit_ocfg = in_blk(reg_idx, `GPCFG_OCFG_BASE);
   assign hit_icfg = in_blk(reg_idx, `GPCFG_ICFG_BASE);
   assign hit_mfs = in_blk(reg_idx, `GPCFG_MFS_BASE);
   assign sel_idx = reg_idx[3:0];
   assign pin_sel = 16'h0001 << sel_idx;
   assign req = i_avs_read | i_avs_write;
   assign wr_go = i_avs_write & ~o_avs_waitrequest & i_avs_byteenable[0];
   assign wd = i_avs_writedata[7:0];

   // ----------------------------------------------------------------
   // Bus handshake
   // ----------------------------------------------------------------
   // One wait cycle per access keeps read data coming from a flop
   always @(posedge i_sys_clk) begin
      if (i_rst) begin
         o_avs_waitrequest <= 1'b1;
         o_avs_readdata <= 32'h0000_0000;
      end else begin
         o_avs_waitrequest <= ~(req & o_avs_waitrequest);
         if (i_avs_read & o_avs_waitrequest) begin
            o_avs_readdata <= {24'h00_0000, rd_next};
         end
      end
   end

   // ----------------------------------------------------------------
   // Read mux
   // ----------------------------------------------------------------
   always @* begin
      rd_next = 8'h00;
      if (hit_ocfg) begin
         rd_next[`GPCFG_O_INV] = input_invert_reg[sel_idx];
         rd_next[`GPCFG_O_HS] = high_side_drive_on_reg[sel_idx];
         rd_next[`GPCFG_O_LS] = low_side_drive_on_reg[sel_idx];
         rd_next[`GPCFG_O_OPOL] = out_invert_reg[sel_idx];
         rd_next[`GPCFG_O_ANB] = analog_mux_b_on_reg[sel_idx];
         rd_next[`GPCFG_O_ANA] = analog_mux_a_on_reg[sel_idx];
         rd_next[`GPCFG_O_PU] = pullup_on_reg[sel_idx];
         rd_next[`GPCFG_O_PD] = pulldown_on_reg[sel_idx];
      end else if (hit_icfg) begin
         rd_next[`GPCFG_I_LB] = pin_irq_line_b_on_reg[sel_idx];
         rd_next[`GPCFG_I_LA] = pin_irq_line_a_on_reg[sel_idx];
         rd_next[`GPCFG_I_RISE] = rise_edge_flag_reg[sel_idx];
         rd_next[`GPCFG_I_FALL] = fall_edge_flag_reg[sel_idx];
         rd_next[`GPCFG_I_INBUF] = input_buffer_on_reg[sel_idx];
         rd_next[`GPCFG_I_CHK] = drive_check_flag_reg[sel_idx];
         rd_next[`GPCFG_I_FILT] = filtered_level[sel_idx];
         rd_next[`GPCFG_I_RAW] = raw_level[sel_idx];
      end else if (hit_mfs) begin
         rd_next = o_function_select_value[{sel_idx, 3'b000} +: 8];
      end
   end

   // ----------------------------------------------------------------
   // Configuration writes
   // ----------------------------------------------------------------
   always @(posedge i_sys_clk) begin
      if (i_rst) begin
         for (i = 0; i < `GPCFG_PINS; i = i + 1) begin
            {input_invert_reg[i], high_side_drive_on_reg[i], low_side_drive_on_reg[i],
             out_invert_reg[i], analog_mux_b_on_reg[i], analog_mux_a_on_reg[i],
             pullup_on_reg[i], pulldown_on_reg[i]} <= `GPCFG_OCFG_RST;
            {pin_irq_line_b_on_reg[i], pin_irq_line_a_on_reg[i], rise_edge_irq_on_reg[i],
             fall_edge_irq_on_reg[i], input_buffer_on_reg[i], drive_check_on_reg[i],
             filter_time_sel_reg[2*i +: 2]} <= `GPCFG_ICFG_RST;
            o_function_select_value[i*8 +: 8] <= `GPCFG_MFS_RST;
         end
      end else if (wr_go) begin
         if (hit_ocfg) begin
            input_invert_reg[sel_idx] <= wd[`GPCFG_O_INV];
            high_side_drive_on_reg[sel_idx] <= wd[`GPCFG_O_HS];
            low_side_drive_on_reg[sel_idx] <= wd[`GPCFG_O_LS];
            out_invert_reg[sel_idx] <= wd[`GPCFG_O_OPOL];
            analog_mux_b_on_reg[sel_idx] <= wd[`GPCFG_O_ANB];
            analog_mux_a_on_reg[sel_idx] <= wd[`GPCFG_O_ANA];
            pullup_on_reg[sel_idx] <= wd[`GPCFG_O_PU];
            pulldown_on_reg[sel_idx] <= wd[`GPCFG_O_PD];
         end
         if (hit_icfg) begin
            pin_irq_line_b_on_reg[sel_idx] <= wd[`GPCFG_I_LB];
            pin_irq_line_a_on_reg[sel_idx] <= wd[`GPCFG_I_LA];
            rise_edge_irq_on_reg[sel_idx] <= wd[`GPCFG_I_RISE];
            fall_edge_irq_on_reg[sel_idx] <= wd[`GPCFG_I_FALL];
            input_buffer_on_reg[sel_idx] <= wd[`GPCFG_I_INBUF];
            drive_check_on_reg[sel_idx] <= wd[`GPCFG_I_CHK];
            filter_time_sel_reg[{sel_idx, 1'b0} +: 2] <= wd[1:0];
         end
         if (hit_mfs) begin
            o_function_select_value[{sel_idx, 3'b000} +: 8] <= wd;
         end
      end
   end

   assign o_pullup_on = pullup_on_reg;
   assign o_pulldown_on = pulldown_on_reg;
   assign o_analog_mux_a_on = analog_mux_a_on_reg;
   assign o_analog_mux_b_on = analog_mux_b_on_reg;
   assign o_input_buffer_on = input_buffer_on_reg;

   // ----------------------------------------------------------------
   // Input path
   // ----------------------------------------------------------------
   always @(posedge i_sys_clk) begin
      if (i_rst) begin
         pin_s1_reg <= 16'h0000;
         pin_s2_reg <= 16'h0000;
         osc_s1_reg <= 1'b0;
         osc_s2_reg <= 1'b0;
         osc_s3_reg <= 1'b0;
         slow_osc_tick_reg <= 1'b0;
      end else begin
         pin_s1_reg <= i_pin_in;
         pin_s2_reg <= pin_s1_reg;
         osc_s1_reg <= i_slow_osc_clk;
         osc_s2_reg <= osc_s1_reg;
         osc_s3_reg <= osc_s2_reg;
         slow_osc_tick_reg <= osc_s2_reg & ~osc_s3_reg;
      end
   end

   // A disabled buffer reads 0 before any inversion is applied
   assign raw_level = pin_s2_reg & input_buffer_on_reg;
   assign in_level = raw_level ^ input_invert_reg;

   generate
      for (g = 0; g < `GPCFG_PINS; g = g + 1) begin : filt
         gpcfg_filter u_filter (
            .i_sys_clk(i_sys_clk),
            .i_rst(i_rst),
            .i_level(in_level[g]),
            .i_tick(slow_osc_tick_reg),
            .i_sel(filter_time_sel_reg[2*g +: 2]),
            .o_level(filtered_level[g])
         );
      end
   endgenerate

   assign o_filtered_level = filtered_level;

   // ----------------------------------------------------------------
   // Flag helpers
   // ----------------------------------------------------------------
   // Per-pin clear mask of a write of 0 to one enable of the input register
   function [15:0] clr_mask;
      input wr_icfg;
      input en_bit;
      input [15:0] sel;
      begin
         clr_mask = (wr_icfg & ~en_bit) ? sel : 16'h0000;
      end
   endfunction

   // Set wins over clear, so an event in the clearing cycle is never lost
   function [15:0] flag_upd;
      input [15:0] set;
      input [15:0] old;
      input [15:0] clr;
      begin
         flag_upd = set | (old & ~clr);
      end
   endfunction

   // ----------------------------------------------------------------
   // Edge flags
   // ----------------------------------------------------------------
   assign rise_evt = filtered_level & ~filt_prev_reg;
   assign fall_evt = ~filtered_level & filt_prev_reg;
   assign line_any_on = pin_irq_line_a_on_reg | pin_irq_line_b_on_reg;
   assign rise_clr = clr_mask(wr_go & hit_icfg, wd[`GPCFG_I_RISE], pin_sel);
   assign fall_clr = clr_mask(wr_go & hit_icfg, wd[`GPCFG_I_FALL], pin_sel);
   assign chk_clr = clr_mask(wr_go & hit_icfg, wd[`GPCFG_I_CHK], pin_sel);

   // ----------------------------------------------------------------
   // Output drive and check
   // ----------------------------------------------------------------
   assign drv_next = i_port_out_data ^ out_invert_reg;
   assign oe_next = (drv_next & high_side_drive_on_reg) |
                    (~drv_next & low_side_drive_on_reg);
   assign mismatch = chk_pipe_reg[`GPCFG_CHK_DELAY-1] & drive_check_on_reg &
                     (pin_s2_reg ^ exp_pipe_reg[`GPCFG_CHK_DELAY-1]);
   assign flag_any = rise_edge_flag_reg | fall_edge_flag_reg | drive_check_flag_reg;

   // An event in the clearing cycle wins over the clear
   always @(posedge i_sys_clk) begin
      if (i_rst) begin
         filt_prev_reg <= 16'h0000;
         drv_prev_reg <= 16'h0000;
         rise_edge_flag_reg <= 16'h0000;
         fall_edge_flag_reg <= 16'h0000;
         drive_check_flag_reg <= 16'h0000;
         o_pin_out <= 16'h0000;
         o_pin_oe <= 16'h0000;
         o_pin_irq_line_a <= 1'b0;
         o_pin_irq_line_b <= 1'b0;
         for (j = 0; j < `GPCFG_CHK_DELAY; j = j + 1) begin
            chk_pipe_reg[j] <= 16'h0000;
            exp_pipe_reg[j] <= 16'h0000;
         end
      end else begin
         filt_prev_reg <= filtered_level;
         o_pin_out <= drv_next;
         o_pin_oe <= oe_next;
         drv_prev_reg <= o_pin_out;
         chk_pipe_reg[0] <= o_pin_out ^ drv_prev_reg;
         exp_pipe_reg[0] <= o_pin_out;
         for (j = 1; j < `GPCFG_CHK_DELAY; j = j + 1) begin
            chk_pipe_reg[j] <= chk_pipe_reg[j-1];
            exp_pipe_reg[j] <= exp_pipe_reg[j-1];
         end
         rise_edge_flag_reg <= flag_upd(rise_evt & rise_edge_irq_on_reg & line_any_on,
                                        rise_edge_flag_reg, rise_clr);
         fall_edge_flag_reg <= flag_upd(fall_evt & fall_edge_irq_on_reg & line_any_on,
                                        fall_edge_flag_reg, fall_clr);
         drive_check_flag_reg <= flag_upd(mismatch, drive_check_flag_reg, chk_clr);
         o_pin_irq_line_a <= |(flag_any & pin_irq_line_a_on_reg);
         o_pin_irq_line_b <= |(flag_any & pin_irq_line_b_on_reg);
      end
   end

endmodule

// *** include/gpcfg_regs.vh ***
`ifndef GPCFG_REGS_VH
`define GPCFG_REGS_VH

// ----------------------------------------------------------------
// Register map (indices; byte address is four times the index)
// ----------------------------------------------------------------
`define GPCFG_OCFG_BASE 16'ha100
`define GPCFG_ICFG_BASE 16'ha110
`define GPCFG_MFS_BASE 16'ha120
`define GPCFG_PINS 16

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define GPCFG_OCFG_RST 8'h00
`define GPCFG_ICFG_RST 8'h00
`define GPCFG_MFS_RST 8'h00

// ----------------------------------------------------------------
// Output configuration fields
// ----------------------------------------------------------------
`define GPCFG_O_INV 7
`define GPCFG_O_HS 6
`define GPCFG_O_LS 5
`define GPCFG_O_OPOL 4
`define GPCFG_O_ANB 3
`define GPCFG_O_ANA 2
`define GPCFG_O_PU 1
`define GPCFG_O_PD 0

// ----------------------------------------------------------------
// Input configuration fields
// ----------------------------------------------------------------
`define GPCFG_I_LB 7
`define GPCFG_I_LA 6
`define GPCFG_I_RISE 5
`define GPCFG_I_FALL 4
`define GPCFG_I_INBUF 3
`define GPCFG_I_CHK 2
`define GPCFG_I_FILT 1
`define GPCFG_I_RAW 0

// ----------------------------------------------------------------
// Timing counts
// ----------------------------------------------------------------
`define GPCFG_FILT_OFF 2'b00
`define GPCFG_FILT_4 2'b01
`define GPCFG_FILT_16 2'b10
`define GPCFG_CNT_4 7'h04
`define GPCFG_CNT_16 7'h10
`define GPCFG_CNT_64 7'h40
`define GPCFG_CHK_DELAY 3

`endif

// *** rtl/gpcfg_filter.v ***
`include "gpcfg_regs.vh"
module gpcfg_filter (
   input wire i_sys_clk,
   input wire i_rst,
   input wire i_level,
   input wire i_tick,
   input wire [1:0] i_sel,
   output reg o_level
);

   reg [6:0] cnt_reg;

   // ----------------------------------------------------------------
   // Tick count needed per selection
   // ----------------------------------------------------------------
   function [6:0] filt_limit;
      input [1:0] sel;
      begin
         case (sel)
            `GPCFG_FILT_4: filt_limit = `GPCFG_CNT_4;
            `GPCFG_FILT_16: filt_limit = `GPCFG_CNT_16;
            default: filt_limit = `GPCFG_CNT_64;
         endcase
      end
   endfunction

   // A new level must stay stable for the selected number of slow ticks
   always @(posedge i_sys_clk) begin
      if (i_rst) begin
         cnt_reg <= 7'h00;
         o_level <= 1'b0;
      end else if (i_sel == `GPCFG_FILT_OFF || i_level == o_level) begin
         cnt_reg <= 7'h00;
         o_level <= i_level;
      end else if (i_tick) begin
         if (cnt_reg + 7'h01 >= filt_limit(i_sel)) begin
            cnt_reg <= 7'h00;
            o_level <= i_level;
         end else begin
            cnt_reg <= cnt_reg + 7'h01;
         end
      end
   end

endmodule

// *** bench/gpcfg_asserts.sv ***
module gpcfg_asserts (
   input wire i_sys_clk,
   input wire i_rst,
   input wire [17:0] i_avs_address,
   input wire i_avs_read,
   input wire i_avs_write,
   input wire [31:0] i_avs_writedata,
   input wire [3:0] i_avs_byteenable,
   input wire [31:0] o_avs_readdata,
   input wire o_avs_waitrequest,
   input wire [15:0] i_pin_in,
   input wire [15:0] o_pin_out,
   input wire [15:0] o_pin_oe,
   input wire [15:0] i_port_out_data,
   input wire i_slow_osc_clk,
   input wire [15:0] o_pullup_on,
   input wire [15:0] o_pulldown_on,
   input wire [15:0] o_analog_mux_a_on,
   input wire [15:0] o_analog_mux_b_on,
   input wire [15:0] o_input_buffer_on,
   input wire [15:0] o_filtered_level,
   input wire [127:0] o_function_select_value,
   input wire o_pin_irq_line_a,
   input wire o_pin_irq_line_b
);
   // ----------------
   // Accepted write decode
   // ----------------
   wire acc_w = i_avs_write && !o_avs_waitrequest && i_avs_byteenable[0];
   wire [11:0] blk = i_avs_address[17:6];
   wire [3:0] pin = i_avs_address[5:2];
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (i_rst);

   property p_wait_one; (i_avs_read || i_avs_write) && o_avs_waitrequest |=> !o_avs_waitrequest;
   endproperty
   a_wait_one: assert property (p_wait_one) else $error("no answer after request");
   property p_wait_pulse; !o_avs_waitrequest |=> o_avs_waitrequest; endproperty
   a_wait_pulse: assert property (p_wait_pulse) else $error("answer held too long");
   property p_reset_idle;
      $fell(i_rst) |-> o_pin_oe == 16'h0000 && o_pullup_on == 16'h0000 && !o_pin_irq_line_a;
   endproperty
   a_reset_idle: assert property (p_reset_idle) else $error("drivers on after reset");
   property p_fsel_write;
      acc_w && blk == 12'ha12 |=>
         8'(o_function_select_value >> {$past(pin), 3'b000}) == $past(i_avs_writedata[7:0]);
   endproperty
   a_fsel_write: assert property (p_fsel_write) else $error("select byte not written");
   property p_pull_write;
      acc_w && blk == 12'ha10 |=>
         {o_pullup_on[$past(pin)], o_pulldown_on[$past(pin)]} == $past(i_avs_writedata[1:0]);
   endproperty
   a_pull_write: assert property (p_pull_write) else $error("pull bits wrong");
   property p_mux_write;
      acc_w && blk == 12'ha10 |=> {o_analog_mux_b_on[$past(pin)], o_analog_mux_a_on[$past(pin)]}
         == $past(i_avs_writedata[3:2]);
   endproperty
   a_mux_write: assert property (p_mux_write) else $error("mux bits wrong");
   property p_buf_write;
      acc_w && blk == 12'ha11 |=> o_input_buffer_on[$past(pin)] == $past(i_avs_writedata[3]);
   endproperty
   a_buf_write: assert property (p_buf_write) else $error("buffer bit wrong");
   property p_cfg_hold;
      $changed({o_pullup_on, o_pulldown_on, o_input_buffer_on, o_function_select_value})
         |-> $past(acc_w);
   endproperty
   a_cfg_hold: assert property (p_cfg_hold) else $error("config moved without write");
   property p_unmapped; i_avs_read && o_avs_waitrequest && blk > 12'ha12 |=> o_avs_readdata == 0;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
   property p_upper_zero; !o_avs_waitrequest |-> o_avs_readdata[31:8] == 24'h0; endproperty
   a_upper_zero: assert property (p_upper_zero) else $error("read upper bits set");

   c_irq_a: cover property (o_pin_irq_line_a);
   c_irq_b: cover property (o_pin_irq_line_b);
   c_fsel: cover property (acc_w && blk == 12'ha12);
   c_unmapped: cover property (i_avs_read && blk == 12'ha13);
endmodule

bind gpcfg_top gpcfg_asserts u_gpcfg_asserts (.*);

// *** bench/gpcfg_pins.sv ***
module gpcfg_pins (
   input wire [15:0] i_pin_out,
   input wire [15:0] i_pin_oe,
   input wire [15:0] i_pullup_on,
   input wire [15:0] i_pulldown_on,
   input wire [15:0] i_board_level,
   input wire [15:0] i_stuck,
   output logic [15:0] o_pad
);
   timeunit 1ns;
   timeprecision 1ns;
   // ----------------
   // Pad level
   // ----------------
   // A stuck pad reads the inverse of what is driven, to provoke the drive check
   always_comb begin
      for (int k = 0; k < 16; k++) begin
         if (i_pin_oe[k])
            o_pad[k] = i_pin_out[k] ^ i_stuck[k];
         else if (i_pullup_on[k])
            o_pad[k] = 1'b1;
         else if (i_pulldown_on[k])
            o_pad[k] = 1'b0;
         else
            o_pad[k] = i_board_level[k];
      end
   end
endmodule

// *** bench/test_gpio_pin_config_and_edge_interrupt.sv ***
module test_gpio_pin_config_and_edge_interrupt;
   timeunit 1ns;
   timeprecision 1ns;
   logic i_sys_clk = 1'b0;
   logic i_rst = 1'b1;
   logic [17:0] i_avs_address = 18'h0;
   logic i_avs_read = 1'b0;
   logic i_avs_write = 1'b0;
   logic [31:0] i_avs_writedata = 32'h0;
   logic [3:0] i_avs_byteenable = 4'h1;
   logic [15:0] i_port_out_data = 16'h0;
   logic i_slow_osc_clk = 1'b0;
   logic [15:0] board = 16'h0;
   logic [15:0] stuck = 16'h0;
   wire [15:0] i_pin_in, o_pin_out, o_pin_oe, o_pullup_on, o_pulldown_on, o_analog_mux_a_on;
   wire [15:0] o_analog_mux_b_on, o_input_buffer_on, o_filtered_level;
   wire [31:0] o_avs_readdata;
   wire [127:0] o_function_select_value;
   wire o_avs_waitrequest, o_pin_irq_line_a, o_pin_irq_line_b;
   int n_fail = 0;
   int checks_done = 0;
   logic [7:0] rd;
   logic [7:0] fsv [16];
   // Edge walk per step: write, readback, pad level, line A, line B (bit i = step i)
   logic [7:0] st_w [8] = '{8'h78, 8'h78, 8'h78, 8'h58, 8'h48, 8'hb8, 8'h38, 8'h08};
   logic [7:0] st_e [8] = '{8'h48, 8'h6b, 8'h78, 8'h58, 8'h48, 8'hab, 8'h28, 8'h0b};
   logic [7:0] st_lvl = 8'ha2;
   logic [7:0] st_a = 8'h0e;
   logic [7:0] st_b = 8'h20;

   gpcfg_top dut (.*);
   gpcfg_pins u_pins (.i_pin_out(o_pin_out), .i_pin_oe(o_pin_oe), .i_pullup_on(o_pullup_on),
      .i_pulldown_on(o_pulldown_on), .i_board_level(board), .i_stuck(stuck), .o_pad(i_pin_in));

   initial begin
      forever #25 i_sys_clk = ~i_sys_clk;
   end
   // Slow oscillator far faster than real, so the 64-tick filter stays short
   initial begin
      #7;
      forever #150 i_slow_osc_clk = ~i_slow_osc_clk;
   end

   // ----------------
   // Helpers
   // ----------------
   function int ticks(input logic [1:0] s);
      return 4 ** s;
   endfunction
   function logic drive_on(input logic v, input logic [7:0] c);
      return (v ^ c[4]) ? c[6] : c[5];
   endfunction
   task check(input string nm, input logic [31:0] e, input logic [31:0] g);
      checks_done++;
      if (g !== e) begin
         n_fail++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task bus(input logic w, input logic [15:0] idx, input logic [7:0] wd, output logic [7:0] r);
      int n;
      n = 0;
      @(posedge i_sys_clk);
      i_avs_address <= {idx, 2'b00};
      i_avs_writedata <= {24'h0, wd};
      i_avs_write <= w;
      i_avs_read <= !w;
      do begin
         @(posedge i_sys_clk);
         n++;
      end while (o_avs_waitrequest !== 1'b0);
      r = o_avs_readdata[7:0];
      check("wait cycles", 32'd2, 32'(n));
      i_avs_write <= 1'b0;
      i_avs_read <= 1'b0;
   endtask
   task wr(input logic [15:0] idx, input logic [7:0] d);
      logic [7:0] x;
      bus(1'b1, idx, d, x);
   endtask
   task rdchk(input string nm, input logic [15:0] idx, input logic [7:0] e);
      bus(1'b0, idx, 8'h00, rd);
      check(nm, e, rd);
   endtask
   task wait_cyc(input int n);
      repeat (n) @(posedge i_sys_clk);
   endtask
   task do_reset;
      i_rst <= 1'b1;
      wait_cyc(8);
      i_rst <= 1'b0;
   endtask
   task t_reset;
      for (int i = 0; i < 16; i++) begin
         rdchk("in cfg", 16'ha110 + 16'(i), 8'h00);
         rdchk("out cfg", 16'ha100 + 16'(i), 8'h00);
         rdchk("fsel reg", 16'ha120 + 16'(i), 8'h00);
      end
      rdchk("unmapped", 16'ha130, 8'h00);
      check("oe", 32'h0, o_pin_oe);
      $display("test reset values done");
   endtask
   task complete_run;
      $display("checks %0d mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   initial begin
      wait_cyc(20000);
      n_fail++;
      $display("[FAIL] watchdog expected done seen hang");
      complete_run;
   end

   // ----------------
   // Tests
   // ----------------
   initial begin
      int p;
      logic [7:0] d;
      logic lvl;
      void'($urandom(10770));
      do_reset;
      t_reset;
      for (int i = 0; i < 16; i++) begin
         fsv[i] = 8'($urandom);
         wr(16'ha120 + 16'(i), fsv[i]);
      end
      for (int i = 0; i < 16; i++) begin
         rdchk("fsel reg", 16'ha120 + 16'(i), fsv[i]);
         check("fsel out", fsv[i], o_function_select_value[8*i +: 8]);
      end
      $display("test function select done");
      repeat (12) begin
         p = $urandom_range(15);
         d = 8'($urandom);
         i_port_out_data <= 16'($urandom);
         wr(16'ha100 + 16'(p), d);
         wait_cyc(2);
         check("pull-up", d[1], o_pullup_on[p]);
         check("pull-down", d[0], o_pulldown_on[p]);
         check("mux a", d[2], o_analog_mux_a_on[p]);
         check("mux b", d[3], o_analog_mux_b_on[p]);
         check("pin out", i_port_out_data[p] ^ d[4], o_pin_out[p]);
         check("drive", drive_on(i_port_out_data[p], d), o_pin_oe[p]);
         rdchk("out cfg", 16'ha100 + 16'(p), d);
         wr(16'ha100 + 16'(p), 8'h00);
      end
      $display("test output config done");
      p = $urandom_range(15);
      board[p] <= 1'b1;
      wr(16'ha110 + 16'(p), 8'h08);
      wait_cyc(6);
      rdchk("buffer on", 16'ha110 + 16'(p), 8'h0b);
      check("filtered", 1'b1, o_filtered_level[p]);
      check("buffer out", 1'b1, o_input_buffer_on[p]);
      wr(16'ha100 + 16'(p), 8'h80);
      wait_cyc(6);
      rdchk("invert", 16'ha110 + 16'(p), 8'h09);
      wr(16'ha110 + 16'(p), 8'h00);
      wait_cyc(6);
      rdchk("buffer off", 16'ha110 + 16'(p), 8'h02);
      wr(16'ha100 + 16'(p), 8'h00);
      board[p] <= 1'b0;
      wait_cyc(6);
      $display("test buffer and invert done");
      for (int i = 0; i < 8; i++) begin
         wr(16'ha110 + 16'(p), st_w[i]);
         board[p] <= st_lvl[i];
         wait_cyc(10);
         rdchk("edge flags", 16'ha110 + 16'(p), st_e[i]);
         check("line a", st_a[i], o_pin_irq_line_a);
         check("line b", st_b[i], o_pin_irq_line_b);
      end
      $display("test edge flags done");
      for (int s = 1; s < 4; s++) begin
         wr(16'ha110 + 16'(p), 8'h08 | 8'(s));
         wait_cyc(20);
         lvl = board[p];
         board[p] <= !lvl;
         wait_cyc(6 * (ticks(2'(s)) - 2));
         check("filter early", lvl, o_filtered_level[p]);
         wait_cyc(30);
         check("filter late", !lvl, o_filtered_level[p]);
      end
      $display("test filter done");
      wr(16'ha100 + 16'(p), 8'h60);
      wr(16'ha110 + 16'(p), 8'h0c);
      i_port_out_data[p] <= !i_port_out_data[p];
      wait_cyc(10);
      lvl = i_port_out_data[p];
      rdchk("drive match", 16'ha110 + 16'(p), {6'h02, lvl, lvl});
      stuck[p] <= 1'b1;
      i_port_out_data[p] <= !lvl;
      wait_cyc(10);
      rdchk("drive fault", 16'ha110 + 16'(p), {6'h03, lvl, lvl});
      check("no line", 1'b0, o_pin_irq_line_a | o_pin_irq_line_b);
      wr(16'ha110 + 16'(p), 8'h4c);
      wait_cyc(4);
      check("line a fault", 1'b1, o_pin_irq_line_a);
      wr(16'ha110 + 16'(p), 8'h48);
      wait_cyc(4);
      check("fault off", 1'b0, o_pin_irq_line_a);
      rdchk("flag clear", 16'ha110 + 16'(p), {6'h12, lvl, lvl});
      $display("test drive check done");
      do_reset;
      t_reset;
      complete_run;
   end
endmodule
